/* File: verilog/rsal_core.v */
// Execution datapath: rotate, subtracts, nibble exchange, sleep, APB access
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "rsal_defs.vh"
module rsal_core (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Decoder command
  input  wire        op_valid,
  input  wire [2:0]  op_code,
  input  wire        op_dest,
  input  wire [6:0]  op_file_addr,
  input  wire [7:0]  op_literal,
  // Completion
  output reg         op_done,
  output reg  [7:0]  op_result
);

  localparam AP_IDLE = 2'h0;
  localparam AP_WAIT = 2'h1;
  localparam AP_DONE = 2'h2;

  reg  [7:0] acc_reg;
  reg        c_reg;
  reg        hc_reg;
  reg        z_reg;
  reg        pwrdn_reg;
  reg        expiry_reg;
  reg        wdog_en_reg;
  reg  [7:0] wdog_cnt_reg;
  reg  [7:0] wdog_pre_reg;
  reg        s2_reg;
  reg  [2:0] s2_op_reg;
  reg        s2_dest_reg;
  reg  [6:0] s2_addr_reg;
  reg  [7:0] s2_lit_reg;
  reg        fwd_reg;
  reg  [7:0] fwd_data_reg;
  reg  [1:0] ap_state_reg;
  reg  [1:0] ap_state_next;

  wire [7:0] mem_rdata;
  wire       mem_we;
  wire [6:0] mem_waddr;
  wire [7:0] mem_wdata;
  wire [6:0] mem_raddr;

  // ----------------------------------------------------------------
  // Stage two arithmetic
  // ----------------------------------------------------------------
  wire [7:0] file_val = fwd_reg ? fwd_data_reg : mem_rdata;
  wire       is_lit   = (s2_op_reg == `RSAL_OP_LIT_SUB);
  wire       is_subb  = (s2_op_reg == `RSAL_OP_FILE_SUBB);
  wire       is_sub   = is_lit | is_subb | (s2_op_reg == `RSAL_OP_FILE_SUB);
  wire       is_sleep = (s2_op_reg == `RSAL_OP_SLEEP);
  wire       is_fileop = (s2_op_reg == `RSAL_OP_ROT_RC) | (s2_op_reg == `RSAL_OP_FILE_SUB) |
                         is_subb | (s2_op_reg == `RSAL_OP_NIB_EXCH);
  wire [7:0] minuend  = is_lit ? s2_lit_reg : file_val;
  wire       sub_cin  = is_subb ? c_reg : 1'b1;
  // Two's complement subtract: a + ~w + cin, carry out is the no-borrow flag
  wire [8:0] diff9    = {1'b0, minuend} + {1'b0, ~acc_reg} + {8'h00, sub_cin};
  wire [4:0] nib5     = {1'b0, minuend[3:0]} + {1'b0, ~acc_reg[3:0]} + {4'h0, sub_cin};

  reg  [7:0] result;
  always @* begin
    case (s2_op_reg)
      `RSAL_OP_ROT_RC:   result = {c_reg, file_val[7:1]};
      `RSAL_OP_NIB_EXCH: result = {file_val[3:0], file_val[7:4]};
      `RSAL_OP_LIT_SUB,
      `RSAL_OP_FILE_SUB,
      `RSAL_OP_FILE_SUBB: result = diff9[7:0];
      default:           result = 8'h00;
    endcase
  end

  wire s2_file_wr = s2_reg & is_fileop & (s2_dest_reg == `RSAL_DEST_FILE);
  wire s2_acc_wr  = s2_reg & (is_lit | (is_fileop & (s2_dest_reg == `RSAL_DEST_ACC)));

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire       ap_req   = psel & penable;
  wire       ap_win   = (paddr[11:9] == `RSAL_FILE_BASE);
  wire       ap_hit   = ap_win | (paddr == `RSAL_ACC_OFS) | (paddr == `RSAL_STATUS_OFS) |
                        (paddr == `RSAL_WDCTRL_OFS) | (paddr == `RSAL_WDCOUNT_OFS);
  wire       ap_free  = ~op_valid & ~s2_reg;
  wire       ap_wr    = (ap_state_reg == AP_DONE) & ap_req & pwrite;
  wire       wr_acc   = ap_wr & (paddr == `RSAL_ACC_OFS);
  wire       wr_stat  = ap_wr & (paddr == `RSAL_STATUS_OFS);
  wire       wr_ctrl  = ap_wr & (paddr == `RSAL_WDCTRL_OFS);
  wire       wr_mem   = ap_wr & ap_win;

  always @* begin
    ap_state_next = ap_state_reg;
    case (ap_state_reg)
      AP_IDLE: begin
        if (ap_req & ap_free) begin
          ap_state_next = (ap_win & ~pwrite) ? AP_WAIT : AP_DONE;
        end
      end
      AP_WAIT: ap_state_next = AP_DONE;
      AP_DONE: ap_state_next = AP_IDLE;
      default: ap_state_next = AP_IDLE;
    endcase
  end

  reg [31:0] reg_rdata;
  always @* begin
    case (paddr)
      `RSAL_ACC_OFS:     reg_rdata = {24'h000000, acc_reg};
      `RSAL_STATUS_OFS:  reg_rdata = {27'h0000000, expiry_reg, pwrdn_reg, z_reg, hc_reg, c_reg};
      `RSAL_WDCTRL_OFS:  reg_rdata = {31'h00000000, wdog_en_reg};
      `RSAL_WDCOUNT_OFS: reg_rdata = {16'h0000, wdog_pre_reg, wdog_cnt_reg};
      default:           reg_rdata = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ap_state_reg <= AP_IDLE;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      prdata       <= 32'h00000000;
    end else begin
      ap_state_reg <= ap_state_next;
      pready       <= (ap_state_next == AP_DONE);
      if (ap_state_next == AP_DONE) begin
        pslverr <= ~ap_hit;
        if (pwrite | ~ap_hit) begin
          prdata <= 32'h00000000;
        end else if (ap_win) begin
          prdata <= {24'h000000, mem_rdata};
        end else begin
          prdata <= reg_rdata;
        end
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // File memory and write-read forwarding
  // ----------------------------------------------------------------
  assign mem_we    = s2_file_wr | wr_mem;
  assign mem_waddr = s2_file_wr ? s2_addr_reg : paddr[8:2];
  assign mem_wdata = s2_file_wr ? result : pwdata[7:0];
  assign mem_raddr = op_valid ? op_file_addr : paddr[8:2];

  rsal_file_mem u_mem (
    .pclk    (pclk),
    .wr_en   (mem_we),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_addr (mem_raddr),
    .rd_data (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Pipeline stage and completion
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s2_reg       <= 1'b0;
      s2_op_reg    <= `RSAL_OP_NONE;
      s2_dest_reg  <= `RSAL_DEST_FILE;
      s2_addr_reg  <= 7'h00;
      s2_lit_reg   <= 8'h00;
      fwd_reg      <= 1'b0;
      fwd_data_reg <= 8'h00;
      op_done      <= 1'b0;
      op_result    <= 8'h00;
    end else begin
      s2_reg       <= op_valid & (op_code != `RSAL_OP_NONE);
      s2_op_reg    <= op_valid ? op_code : `RSAL_OP_NONE;
      s2_dest_reg  <= op_dest;
      s2_addr_reg  <= op_file_addr;
      s2_lit_reg   <= op_literal;
      fwd_reg      <= mem_we & (mem_waddr == mem_raddr);
      fwd_data_reg <= mem_wdata;
      op_done      <= s2_reg;
      if (s2_reg & ~is_sleep) begin
        op_result <= result;
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and status flags
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= `RSAL_ACC_RST;
      c_reg   <= 1'b0;
      hc_reg  <= 1'b0;
      z_reg   <= 1'b0;
    end else begin
      if (s2_acc_wr) begin
        acc_reg <= result;
      end else if (wr_acc) begin
        acc_reg <= pwdata[7:0];
      end
      if (s2_reg & is_sub) begin
        c_reg  <= diff9[8];
        hc_reg <= nib5[4];
        z_reg  <= (diff9[7:0] == 8'h00);
      end else if (s2_reg & (s2_op_reg == `RSAL_OP_ROT_RC)) begin
        c_reg  <= file_val[0];
      end else if (wr_stat) begin
        c_reg  <= pwdata[`RSAL_ST_C];
        hc_reg <= pwdata[`RSAL_ST_HC];
        z_reg  <= pwdata[`RSAL_ST_Z];
      end
    end
  end

  // ----------------------------------------------------------------
  // Watchdog counter, prescaler and power flags
  // ----------------------------------------------------------------
  wire wdog_tick   = wdog_en_reg & (wdog_pre_reg == `RSAL_WDOG_TERM);
  wire wdog_expire = wdog_tick & (wdog_cnt_reg == `RSAL_WDOG_TERM);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_en_reg  <= 1'b0;
      wdog_cnt_reg <= `RSAL_WDOG_RST;
      wdog_pre_reg <= `RSAL_PRE_RST;
      pwrdn_reg    <= `RSAL_PWRDN_RST;
      expiry_reg   <= `RSAL_EXPIRY_RST;
    end else begin
      if (wr_ctrl) begin
        wdog_en_reg <= pwdata[0];
      end
      if (s2_reg & is_sleep) begin
        wdog_cnt_reg <= 8'h00;
        wdog_pre_reg <= 8'h00;
        pwrdn_reg    <= 1'b0;
        expiry_reg   <= 1'b1;
      end else begin
        if (wdog_en_reg) begin
          wdog_pre_reg <= wdog_pre_reg + 8'h01;
        end
        if (wdog_tick) begin
          wdog_cnt_reg <= wdog_cnt_reg + 8'h01;
        end
        // Time-out beats a software write in the same cycle
        if (wdog_expire) begin
          expiry_reg <= 1'b0;
        end else if (wr_stat) begin
          expiry_reg <= pwdata[`RSAL_ST_EXPIRY];
        end
        if (wr_stat) begin
          pwrdn_reg <= pwdata[`RSAL_ST_PWRDN];
        end
      end
    end
  end

endmodule

/* File: verilog/rsal_defs.vh */
// Constants for the rotate/subtract/swap/sleep execution datapath
`ifndef RSAL_DEFS_VH
`define RSAL_DEFS_VH

// ----------------------------------------------------------------
// Operation codes on op_code
// ----------------------------------------------------------------
`define RSAL_OP_NONE      3'h0
`define RSAL_OP_ROT_RC    3'h1
`define RSAL_OP_LIT_SUB   3'h2
`define RSAL_OP_FILE_SUB  3'h3
`define RSAL_OP_FILE_SUBB 3'h4
`define RSAL_OP_NIB_EXCH  3'h5
`define RSAL_OP_SLEEP     3'h6

// ----------------------------------------------------------------
// Destination select
// ----------------------------------------------------------------
`define RSAL_DEST_ACC     1'b0
`define RSAL_DEST_FILE    1'b1

// ----------------------------------------------------------------
// APB register byte offsets
// ----------------------------------------------------------------
`define RSAL_ACC_OFS      12'h000
`define RSAL_STATUS_OFS   12'h004
`define RSAL_WDCTRL_OFS   12'h008
`define RSAL_WDCOUNT_OFS  12'h00c
`define RSAL_FILE_BASE    3'h1

// ----------------------------------------------------------------
// Status field positions and reset values
// ----------------------------------------------------------------
`define RSAL_ST_C         0
`define RSAL_ST_HC        1
`define RSAL_ST_Z         2
`define RSAL_ST_PWRDN     3
`define RSAL_ST_EXPIRY    4
`define RSAL_ACC_RST      8'h00
`define RSAL_PWRDN_RST    1'b1
`define RSAL_EXPIRY_RST   1'b1
`define RSAL_WDOG_RST     8'h00
`define RSAL_PRE_RST      8'h00

// ----------------------------------------------------------------
// Watchdog terminal count for prescaler and counter
// ----------------------------------------------------------------
`define RSAL_WDOG_TERM    8'hff

`endif

/* File: verilog/rsal_file_mem.v */
// File register memory, 128 x 8, one write port, registered read port
`timescale 1ns/1ps
module rsal_file_mem (
  // Clock
  input  wire       pclk,
  // Write port
  input  wire       wr_en,
  input  wire [6:0] wr_addr,
  input  wire [7:0] wr_data,
  // Read port
  input  wire [6:0] rd_addr,
  output reg  [7:0] rd_data
);

  reg [7:0] mem_reg [0:127];

  always @(posedge pclk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
    rd_data <= mem_reg[rd_addr];
  end

endmodule

/* File: verif/rsal_core_chk.sv */
// Port checker for the execution datapath
`timescale 1ns/1ps
`include "rsal_defs.vh"
module rsal_core_chk (
  // Clock and reset
  input logic        pclk,
  input logic        presetn,
  // APB
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // Decoder command and completion
  input logic        op_valid,
  input logic [2:0]  op_code,
  input logic        op_dest,
  input logic [6:0]  op_file_addr,
  input logic [7:0]  op_literal,
  input logic        op_done,
  input logic [7:0]  op_result
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_DONE_LAT: assert property (op_valid && op_code != 3'h0 |-> ##2 op_done)
    else $error("op_done late");
  AST_DONE_SRC: assert property (op_done |-> $past(op_valid, 2) && $past(op_code, 2) != 3'h0)
    else $error("op_done without op");
  AST_RES_HOLD: assert property (!op_done |-> $stable(op_result))
    else $error("op_result moved");
  AST_SLEEP_RES: assert property (op_done && $past(op_code, 2) == `RSAL_OP_SLEEP
    |-> $stable(op_result))
    else $error("sleep changed op_result");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  AST_ERR_DATA: assert property (pslverr |-> prdata == 32'h0)
    else $error("error data not zero");
  AST_UNMAP: assert property (pready && paddr[11:9] == 3'h0 && paddr[8:4] != 5'h00 |-> pslverr)
    else $error("unmapped not refused");
  cover property (op_done && $past(op_code, 2) == `RSAL_OP_ROT_RC);
  cover property (op_done && $past(op_code, 2) == `RSAL_OP_SLEEP);
  cover property (pslverr);
endmodule

bind rsal_core rsal_core_chk u_rsal_core_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code),
  .op_dest(op_dest), .op_file_addr(op_file_addr), .op_literal(op_literal),
  .op_done(op_done), .op_result(op_result));

/* File: verif/rsal_dec_model.sv */
// Decoder model: issues one operation on file register 0x2a per call
`timescale 1ns/1ps
module rsal_dec_model (
  // Clock
  input  logic       pclk,
  // Command
  output logic       op_valid,
  output logic [2:0] op_code,
  output logic       op_dest,
  output logic [6:0] op_file_addr,
  output logic [7:0] op_literal
);
  initial begin
    op_valid = 1'b0;
    op_code = 3'h0;
    op_dest = 1'b1;
    op_file_addr = 7'h2a;
    op_literal = 8'h00;
  end
  task automatic issue(input logic [2:0] k, input logic d, input logic [7:0] l);
    @(posedge pclk);
    op_valid <= 1'b1;
    op_code <= k;
    op_dest <= d;
    op_literal <= l;
    @(posedge pclk);
    op_valid <= 1'b0;
    op_code <= 3'h0;
    op_dest <= 1'b1;
    op_literal <= ~l;
  endtask
endmodule

/* File: verif/rsal_core_test.sv */
// Self-checking bench for the execution datapath
`timescale 1ns/1ps
`include "rsal_defs.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module rsal_core_test;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        op_valid;
  logic [2:0]  op_code;
  logic        op_dest;
  logic [6:0]  op_file_addr;
  logic [7:0]  op_literal;
  logic        op_done;
  logic [7:0]  op_result;
  logic [31:0] rdat;
  logic        rerr;
  logic [10:0] s;
  int          err_count;
  int          checked;
  logic [31:0] tc [6];
  localparam logic [11:0] FA = 12'h2a8;

  rsal_core u_rsal_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code), .op_dest(op_dest),
    .op_file_addr(op_file_addr), .op_literal(op_literal), .op_done(op_done),
    .op_result(op_result));
  rsal_dec_model u_rsal_dec_model (.pclk(pclk), .op_valid(op_valid), .op_code(op_code),
    .op_dest(op_dest), .op_file_addr(op_file_addr), .op_literal(op_literal));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [10:0] subr(input logic [7:0] f, w, input logic c);
    logic [8:0] t;
    logic [4:0] h;
    t = {1'b0, f} + {1'b0, ~w} + 9'(c);
    h = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'(c);
    return {t[8], h[4], t[7:0] == 8'h00, t[7:0]};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h0);
    `CHK($sformatf("reg %h", a), {16'h0000, e}, rdat);
    `CHK("pslverr", 1'b0, rerr);
  endtask
  task automatic op(input logic [2:0] k, input logic d, input logic [7:0] l);
    int n;
    u_rsal_dec_model.issue(k, d, l);
    n = 0;
    while (op_done !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    `CHK("op_done", 1'b1, op_done);
  endtask
  task automatic run(input logic [2:0] k, input logic d, input logic [7:0] f, w, st, er, es);
    apb(1'b1, `RSAL_ACC_OFS, {24'h0, w});
    apb(1'b1, `RSAL_STATUS_OFS, {24'h0, st});
    apb(1'b1, FA, {24'h0, f});
    op(k, d, f);
    `CHK("op_result", er, op_result);
    rd(`RSAL_ACC_OFS, {8'h0, d ? w : er});
    rd(FA, {8'h0, d ? er : f});
    rd(`RSAL_STATUS_OFS, {8'h0, es});
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #50000;
    err_count++;
    wrap_up();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    tc = '{32'h20101000, 32'h200f1000, 32'h30503000, 32'h31305000, 32'h41503000,
           32'h40000001};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`RSAL_ACC_OFS, 16'h0000);
    rd(`RSAL_STATUS_OFS, 16'h0018);
    foreach (tc[i]) begin
      s = subr(tc[i][23:16], tc[i][15:8], tc[i][31:28] == 4'h4 ? tc[i][0] : 1'b1);
      run(tc[i][30:28], tc[i][24], tc[i][23:16], tc[i][15:8], 8'h18 | tc[i][7:0],
          s[7:0], {5'h03, s[8], s[9], s[10]});
    end
    run(`RSAL_OP_ROT_RC, 1'b1, 8'h81, 8'h55, 8'h1e, 8'h40, 8'h1f);
    run(`RSAL_OP_ROT_RC, 1'b0, 8'h02, 8'h55, 8'h19, 8'h81, 8'h18);
    run(`RSAL_OP_NIB_EXCH, 1'b0, 8'h3c, 8'h00, 8'h1d, 8'hc3, 8'h1d);
    run(`RSAL_OP_NIB_EXCH, 1'b1, 8'ha5, 8'h11, 8'h02, 8'h5a, 8'h02);
    op(3'h7, 1'b1, 8'h00);
    `CHK("op_result", 8'h00, op_result);
    apb(1'b1, `RSAL_WDCTRL_OFS, 32'h1);
    rd(`RSAL_WDCTRL_OFS, 16'h0001);
    repeat (20) @(posedge pclk);
    apb(1'b1, `RSAL_WDCTRL_OFS, 32'h0);
    apb(1'b1, `RSAL_STATUS_OFS, 32'h0f);
    op(`RSAL_OP_SLEEP, 1'b1, 8'h00);
    rd(`RSAL_WDCOUNT_OFS, 16'h0000);
    rd(`RSAL_STATUS_OFS, 16'h0017);
    apb(1'b0, 12'h100, 32'h0);
    `CHK("pslverr", 1'b1, rerr);
    wrap_up();
  end
endmodule
